// [rtl/nv_memory_command_sequencer.v]
`timescale 1ns/1ps
`include "nv_seq_regs.vh"
// How it works
// - outside user download, user code may read but never alter program array.
// - in user download, user code may erase and program the lower 56 kB.
// - upper 6 kB only writable by serial download or parallel programming.
// - 32 kB variant puts user download region at 24 to 32 kB.
// - 8 kB variant has no user download region at all.
// - with bootload option set, every core reset starts execution at E000H; RSTN clears the option.
// - lock, secure and serial-safe flags are set independently.
// - lock refuses parallel programming, still allows parallel and external reads.
// - secure blocks parallel program/read, external code reads, external data access.
// - lock and secure clear only on code erase in serial or parallel mode; RSTN here also clears both.
// - serial-safe turns a strap-low reset into an ordinary reset.
// - serial-safe clears only on code erase in parallel programming mode; RSTN here also clears it.
// - data page address comes from high and low address registers.
// - a byte is programmed only when it currently reads FFH.
// - erase always clears a whole four-byte page.
// - code 1 reads page, code 5 erases page, code 2 programs page.
// - code 4 compares page, command register reads zero on match.
// - code 06H erases the entire data array.
// - core stalls from command write until the operation completes.
module nv_memory_command_sequencer #(
  parameter [23:0] ERASE_CYCLES = `ERASE_CYCLES
) (
  // clock and reset
  input wire CLK,
  input wire RSTN,
  input wire CORE_RESET,
  // memory command register
  input wire CMD_WE,
  input wire [7:0] CMD_WDATA,
  output wire [7:0] CMD_RDATA,
  // page address registers
  input wire PAGE_ADDR_HIGH_WE,
  input wire PAGE_ADDR_LOW_WE,
  input wire [7:0] PAGE_ADDR_WDATA,
  output wire [7:0] PAGE_ADDR_HIGH,
  output wire [7:0] PAGE_ADDR_LOW,
  // page data registers, one byte lane each
  input wire [3:0] PAGE_DATA_WE,
  input wire [31:0] PAGE_DATA_WDATA,
  output wire [31:0] PAGE_DATA_REGS,
  // core side status
  input wire EXEC_FROM_EXTERNAL,
  output wire EXT_DATA_DENY,
  output wire BUSY,
  output wire CORE_STALL,
  // program array access from user code
  input wire [1:0] VARIANT,
  input wire USER_DOWNLOAD_MODE,
  input wire [15:0] USER_PROG_ADDR,
  input wire USER_PROG_RD_REQ,
  input wire USER_PROG_WR_REQ,
  output wire USER_PROG_RD_GRANT,
  output wire USER_PROG_WR_GRANT,
  // external code reads
  input wire EXT_CODE_READ_REQ,
  output wire EXT_CODE_READ_GRANT,
  // serial download and parallel programming
  input wire DOWNLOAD_STRAP_PIN,
  input wire PARALLEL_MODE,
  input wire [15:0] PROG_ADDR,
  input wire SER_PROG_REQ,
  output wire SER_PROG_GRANT,
  input wire PAR_PROG_REQ,
  output wire PAR_PROG_GRANT,
  input wire PAR_READ_REQ,
  output wire PAR_READ_GRANT,
  // security and boot option
  input wire SEC_LOCK_SET,
  input wire SEC_SECURE_SET,
  input wire SEC_SAFE_SET,
  input wire CODE_ERASE,
  input wire BOOT_OPT_SET,
  input wire BOOT_OPT_CLR,
  output wire LOCK_MODE,
  output wire SECURE_MODE,
  output wire SERIAL_SAFE_MODE,
  output wire BOOT_OPT,
  // reset outcome
  output wire SERIAL_DOWNLOAD,
  output wire [15:0] START_VECTOR,
  output wire START_VALID
);
  localparam ST_IDLE = 1'b0;
  localparam ST_BUSY = 1'b1;
  localparam [23:0] READ_LEN = `READ_CYCLES;
  localparam [23:0] WRITE_LEN = `WRITE_PAGE_CYCLES;

  reg state;
  reg [7:0] op;
  reg [7:0] cmd_reg;
  reg [7:0] addr_high;
  reg [7:0] addr_low;
  reg [31:0] data_regs;
  reg [9:0] sweep;
  reg sweep_done;
  reg lock_mode;
  reg secure_mode;
  reg safe_mode;
  reg boot_opt;
  reg serial_dl;
  reg [15:0] start_vector;
  reg start_valid;
  reg restart;
  reg [31:0] data_mem [0:`DATA_PAGES-1];

  wire ext_block;
  wire [9:0] page;
  wire [31:0] cur_word;
  wire [31:0] prog_word;
  wire [3:0] lane_match;
  wire cmd_known;
  wire cmd_accept;
  wire timer_done;
  wire timer_running;
  reg [23:0] op_len;
  reg mem_we;
  reg [9:0] mem_idx;
  reg [31:0] mem_wdata;
  reg [7:0] next_cmd;

  // secure mode shuts the data array off from code running externally
  assign ext_block = secure_mode & EXEC_FROM_EXTERNAL;
  assign page = {addr_high[1:0], addr_low};
  assign cur_word = data_mem[page];

  genvar i;
  generate
    for (i = 0; i < `PAGE_BYTES; i = i + 1) begin : lane
      // only an erased byte takes the new value
      assign prog_word[8*i+7:8*i] = (cur_word[8*i+7:8*i] == `ERASED_BYTE) ?
        data_regs[8*i+7:8*i] : cur_word[8*i+7:8*i];
      assign lane_match[i] = (cur_word[8*i+7:8*i] == data_regs[8*i+7:8*i]);
    end
  endgenerate

  assign cmd_known = (CMD_WDATA == `CMD_READ_PAGE) || (CMD_WDATA == `CMD_WRITE_PAGE) ||
    (CMD_WDATA == `CMD_VERIFY_PAGE) || (CMD_WDATA == `CMD_ERASE_PAGE) ||
    (CMD_WDATA == `CMD_ERASE_ALL);
  assign cmd_accept = CMD_WE & (state == ST_IDLE) & cmd_known & ~ext_block;

  always @* begin
    case (CMD_WDATA)
      `CMD_READ_PAGE: op_len = READ_LEN;
      `CMD_VERIFY_PAGE: op_len = READ_LEN;
      `CMD_WRITE_PAGE: op_len = WRITE_LEN;
      `CMD_ERASE_PAGE: op_len = ERASE_CYCLES;
      `CMD_ERASE_ALL: op_len = ERASE_CYCLES;
      default: op_len = READ_LEN;
    endcase
  end

  op_timer timer (
    .clk(CLK),
    .rstn(RSTN),
    .start(cmd_accept),
    .length(op_len),
    .running(timer_running),
    .done(timer_done)
  );

  // single write port into the data array
  always @* begin
    mem_we = 1'b0;
    mem_idx = page;
    mem_wdata = `ERASED_WORD;
    if (state == ST_BUSY) begin
      if (op == `CMD_ERASE_ALL) begin
        // one page per cycle while the erase time runs
        mem_we = ~sweep_done;
        mem_idx = sweep;
      end else if (timer_done && op == `CMD_ERASE_PAGE) begin
        mem_we = 1'b1;
      end else if (timer_done && op == `CMD_WRITE_PAGE) begin
        mem_we = 1'b1;
        mem_wdata = prog_word;
      end
    end
  end

  always @(posedge CLK) begin
    if (mem_we) begin
      data_mem[mem_idx] <= mem_wdata;
    end
  end

  always @* begin
    next_cmd = cmd_reg;
    if (state == ST_BUSY && timer_done) begin
      if (op == `CMD_VERIFY_PAGE && lane_match != 4'hF) begin
        next_cmd = `CMD_VERIFY_FAIL;
      end else begin
        next_cmd = `CMD_NONE;
      end
    end else if (cmd_accept) begin
      next_cmd = CMD_WDATA;
    end
  end

  // command sequencer
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      state <= ST_IDLE;
      op <= `CMD_NONE;
      cmd_reg <= `CMD_NONE;
      sweep <= 10'h000;
      sweep_done <= 1'b0;
    end else begin
      cmd_reg <= next_cmd;
      case (state)
        ST_IDLE: begin
          if (cmd_accept) begin
            state <= ST_BUSY;
            op <= CMD_WDATA;
            sweep <= 10'h000;
            sweep_done <= 1'b0;
          end
        end
        ST_BUSY: begin
          if (op == `CMD_ERASE_ALL && !sweep_done) begin
            sweep <= sweep + 10'h001;
            sweep_done <= (sweep == `LAST_PAGE);
          end
          if (timer_done) begin
            state <= ST_IDLE;
            op <= `CMD_NONE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // address and page data registers, frozen while busy
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      addr_high <= 8'h00;
      addr_low <= 8'h00;
      data_regs <= 32'h00000000;
    end else if (state == ST_IDLE && !ext_block) begin
      if (PAGE_ADDR_HIGH_WE) begin
        addr_high <= PAGE_ADDR_WDATA;
      end
      if (PAGE_ADDR_LOW_WE) begin
        addr_low <= PAGE_ADDR_WDATA;
      end
      if (PAGE_DATA_WE[0]) data_regs[7:0] <= PAGE_DATA_WDATA[7:0];
      if (PAGE_DATA_WE[1]) data_regs[15:8] <= PAGE_DATA_WDATA[15:8];
      if (PAGE_DATA_WE[2]) data_regs[23:16] <= PAGE_DATA_WDATA[23:16];
      if (PAGE_DATA_WE[3]) data_regs[31:24] <= PAGE_DATA_WDATA[31:24];
    end else if (state == ST_BUSY && timer_done && op == `CMD_READ_PAGE) begin
      data_regs <= cur_word;
    end
  end

  // security flags: each is set on its own, a set beats a clear in the same cycle
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      lock_mode <= 1'b0;
      secure_mode <= 1'b0;
      safe_mode <= 1'b0;
      boot_opt <= 1'b0;
    end else begin
      if (SEC_LOCK_SET) begin
        lock_mode <= 1'b1;
      end else if (CODE_ERASE && (serial_dl || PARALLEL_MODE)) begin
        lock_mode <= 1'b0;
      end
      if (SEC_SECURE_SET) begin
        secure_mode <= 1'b1;
      end else if (CODE_ERASE && (serial_dl || PARALLEL_MODE)) begin
        secure_mode <= 1'b0;
      end
      if (SEC_SAFE_SET) begin
        safe_mode <= 1'b1;
      end else if (CODE_ERASE && PARALLEL_MODE) begin
        safe_mode <= 1'b0;
      end
      // the boot option is changed only by the serial downloader, and cleared by RSTN
      if (serial_dl && BOOT_OPT_SET) begin
        boot_opt <= 1'b1;
      end else if (serial_dl && BOOT_OPT_CLR) begin
        boot_opt <= 1'b0;
      end
    end
  end

  // reset outcome: the strap is sampled on the first edge after any reset
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      restart <= 1'b1;
      serial_dl <= 1'b0;
      start_vector <= `RESET_VECTOR;
      start_valid <= 1'b0;
    end else if (CORE_RESET) begin
      restart <= 1'b1;
      start_valid <= 1'b0;
    end else if (restart) begin
      restart <= 1'b0;
      start_valid <= 1'b1;
      serial_dl <= ~DOWNLOAD_STRAP_PIN & ~safe_mode;
      start_vector <= boot_opt ? `BOOT_VECTOR : `RESET_VECTOR;
    end
  end

  // program array gating
  reg in_user_dl;
  reg in_prog;
  always @* begin
    in_user_dl = 1'b0;
    in_prog = 1'b0;
    case (VARIANT)
      `VARIANT_62K: begin
        in_user_dl = (USER_PROG_ADDR < `USER_DL_TOP_62K);
        in_prog = (PROG_ADDR < `PROG_TOP_62K);
      end
      `VARIANT_32K: begin
        in_user_dl = (USER_PROG_ADDR >= `USER_DL_BASE_32K) &&
          (USER_PROG_ADDR < `USER_DL_TOP_32K);
        in_prog = (PROG_ADDR < `PROG_TOP_32K) ||
          ((PROG_ADDR >= `BOOT_VECTOR + 16'h1000) && (PROG_ADDR < `PROG_TOP_62K));
      end
      `VARIANT_8K: begin
        in_user_dl = 1'b0;
        in_prog = (PROG_ADDR < `PROG_TOP_8K);
      end
      default: in_user_dl = 1'b0;
    endcase
  end

  reg user_rd_ok;
  always @* begin
    case (VARIANT)
      `VARIANT_62K: user_rd_ok = (USER_PROG_ADDR < `PROG_TOP_62K);
      `VARIANT_32K: user_rd_ok = (USER_PROG_ADDR < `PROG_TOP_32K);
      `VARIANT_8K: user_rd_ok = (USER_PROG_ADDR < `PROG_TOP_8K);
      default: user_rd_ok = 1'b0;
    endcase
  end

  // user writes need download mode and the unprotected region
  assign USER_PROG_WR_GRANT = USER_PROG_WR_REQ & USER_DOWNLOAD_MODE & in_user_dl;
  assign USER_PROG_RD_GRANT = USER_PROG_RD_REQ & user_rd_ok;
  // the protected top is writable only through the two programming paths
  assign SER_PROG_GRANT = SER_PROG_REQ & serial_dl & in_prog;
  assign PAR_PROG_GRANT = PAR_PROG_REQ & PARALLEL_MODE & in_prog &
    ~lock_mode & ~secure_mode;
  assign PAR_READ_GRANT = PAR_READ_REQ & PARALLEL_MODE & ~secure_mode;
  assign EXT_CODE_READ_GRANT = EXT_CODE_READ_REQ & ~secure_mode;

  // outputs
  assign CMD_RDATA = cmd_reg;
  assign PAGE_ADDR_HIGH = addr_high;
  assign PAGE_ADDR_LOW = addr_low;
  assign PAGE_DATA_REGS = data_regs;
  assign EXT_DATA_DENY = ext_block;
  assign BUSY = (state == ST_BUSY) & timer_running;
  assign CORE_STALL = (state == ST_BUSY);
  assign LOCK_MODE = lock_mode;
  assign SECURE_MODE = secure_mode;
  assign SERIAL_SAFE_MODE = safe_mode;
  assign BOOT_OPT = boot_opt;
  assign SERIAL_DOWNLOAD = serial_dl;
  assign START_VECTOR = start_vector;
  assign START_VALID = start_valid;
endmodule

// [inc/nv_seq_regs.vh]
`ifndef NV_SEQ_REGS_VH
`define NV_SEQ_REGS_VH

// command codes and status values of the memory command register
`define CMD_NONE 8'h00
`define CMD_READ_PAGE 8'h01
`define CMD_WRITE_PAGE 8'h02
`define CMD_VERIFY_PAGE 8'h04
`define CMD_ERASE_PAGE 8'h05
`define CMD_ERASE_ALL 8'h06
`define CMD_VERIFY_FAIL 8'h01

// data array
`define ERASED_BYTE 8'hFF
`define ERASED_WORD 32'hFFFFFFFF
`define PAGE_BYTES 4
`define DATA_PAGES 1024
`define LAST_PAGE 10'h3FF

// program array map, byte addresses
`define RESET_VECTOR 16'h0000
`define BOOT_VECTOR 16'hE000
`define USER_DL_BASE_62K 16'h0000
`define USER_DL_TOP_62K 16'hE000
`define PROG_TOP_62K 16'hF800
`define USER_DL_BASE_32K 16'h6000
`define USER_DL_TOP_32K 16'h8000
`define PROG_TOP_32K 16'h8000
`define PROG_TOP_8K 16'h2000

// memory size variants
`define VARIANT_62K 2'h0
`define VARIANT_32K 2'h1
`define VARIANT_8K 2'h2

// timing
`define CLK_KHZ 10000
`define READ_MACHINE_CYCLES 22
`define WRITE_PAGE_US 380
`define ERASE_MS 2
`define READ_CYCLES (`READ_MACHINE_CYCLES)
`define WRITE_PAGE_CYCLES ((`WRITE_PAGE_US * `CLK_KHZ) / 1000)
`define ERASE_CYCLES (`ERASE_MS * `CLK_KHZ)

`endif

// [rtl/op_timer.v]
`timescale 1ns/1ps
module op_timer (
  // clock and reset
  input wire clk,
  input wire rstn,
  // control
  input wire start,
  input wire [23:0] length,
  // status
  output wire running,
  output reg done
);
  reg [23:0] count;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count <= 24'h000000;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        count <= length;
      end else if (count != 24'h000000) begin
        count <= count - 24'h000001;
        if (count == 24'h000001) begin
          done <= 1'b1;
        end
      end
    end
  end

  assign running = (count != 24'h000000);
endmodule

// [rtl/unused_placeholder.v]
`timescale 1ns/1ps

// [dv/nv_seq_properties.sv]
`timescale 1ns/1ps
module nv_seq_properties (
  // clock and reset
  input wire CLK,
  input wire RSTN,
  // command side
  input wire [7:0] CMD_RDATA,
  input wire [31:0] PAGE_DATA_REGS,
  input wire BUSY,
  input wire CORE_STALL,
  input wire EXEC_FROM_EXTERNAL,
  input wire EXT_DATA_DENY,
  // program array access
  input wire [1:0] VARIANT,
  input wire USER_DOWNLOAD_MODE,
  input wire [15:0] USER_PROG_ADDR,
  input wire USER_PROG_WR_GRANT,
  input wire EXT_CODE_READ_REQ,
  input wire EXT_CODE_READ_GRANT,
  input wire PARALLEL_MODE,
  input wire PAR_PROG_GRANT,
  input wire PAR_READ_REQ,
  input wire PAR_READ_GRANT,
  // security and reset outcome
  input wire CODE_ERASE,
  input wire LOCK_MODE,
  input wire SECURE_MODE,
  input wire SERIAL_SAFE_MODE,
  input wire BOOT_OPT,
  input wire SERIAL_DOWNLOAD,
  input wire [15:0] START_VECTOR,
  input wire START_VALID
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  a_deny_when_ext: assert property (EXT_DATA_DENY == (SECURE_MODE && EXEC_FROM_EXTERNAL))
    else $error("data deny mismatch");
  a_ext_code_read: assert property (EXT_CODE_READ_GRANT == (EXT_CODE_READ_REQ && !SECURE_MODE))
    else $error("external code read grant wrong");
  a_par_prog_lock: assert property (PAR_PROG_GRANT |-> PARALLEL_MODE && !LOCK_MODE && !SECURE_MODE)
    else $error("parallel program granted while locked");
  a_par_read_gate: assert property (PAR_READ_GRANT == (PAR_READ_REQ && PARALLEL_MODE && !SECURE_MODE))
    else $error("parallel read grant wrong");
  a_user_wr_region: assert property (USER_PROG_WR_GRANT |-> USER_DOWNLOAD_MODE &&
    ((VARIANT == 2'h0 && USER_PROG_ADDR < 16'hE000) || (VARIANT == 2'h1 &&
    USER_PROG_ADDR >= 16'h6000 && USER_PROG_ADDR < 16'h8000))) else $error("user write out of region");
  a_read_stall_len: assert property ($rose(CORE_STALL) && (CMD_RDATA == 8'h01 ||
    CMD_RDATA == 8'h04) |-> ##22 CORE_STALL ##1 !CORE_STALL) else $error("read stall length wrong");
  a_busy_stalls: assert property (BUSY |-> CORE_STALL)
    else $error("busy without stall");
  a_data_frozen: assert property (BUSY |=> $stable(PAGE_DATA_REGS))
    else $error("page data moved while busy");
  a_lock_clear: assert property ($fell(LOCK_MODE) |-> $past(CODE_ERASE))
    else $error("lock cleared without code erase");
  a_safe_clear: assert property ($fell(SERIAL_SAFE_MODE) |-> $past(CODE_ERASE) && $past(PARALLEL_MODE))
    else $error("safe cleared outside parallel erase");
  a_safe_no_dl: assert property ($rose(START_VALID) && SERIAL_SAFE_MODE |-> !SERIAL_DOWNLOAD)
    else $error("serial download entered in safe mode");
  a_boot_vector: assert property ($rose(START_VALID) |-> START_VECTOR == (BOOT_OPT ? 16'hE000 : 16'h0000))
    else $error("start vector wrong");
endmodule
bind nv_memory_command_sequencer nv_seq_properties u_nv_seq_properties (.CLK(CLK), .RSTN(RSTN),
  .CMD_RDATA(CMD_RDATA), .PAGE_DATA_REGS(PAGE_DATA_REGS), .BUSY(BUSY), .CORE_STALL(CORE_STALL),
  .EXEC_FROM_EXTERNAL(EXEC_FROM_EXTERNAL), .EXT_DATA_DENY(EXT_DATA_DENY), .VARIANT(VARIANT),
  .USER_DOWNLOAD_MODE(USER_DOWNLOAD_MODE), .USER_PROG_ADDR(USER_PROG_ADDR),
  .USER_PROG_WR_GRANT(USER_PROG_WR_GRANT), .EXT_CODE_READ_REQ(EXT_CODE_READ_REQ),
  .EXT_CODE_READ_GRANT(EXT_CODE_READ_GRANT), .PARALLEL_MODE(PARALLEL_MODE),
  .PAR_PROG_GRANT(PAR_PROG_GRANT), .PAR_READ_REQ(PAR_READ_REQ), .PAR_READ_GRANT(PAR_READ_GRANT),
  .CODE_ERASE(CODE_ERASE), .LOCK_MODE(LOCK_MODE), .SECURE_MODE(SECURE_MODE),
  .SERIAL_SAFE_MODE(SERIAL_SAFE_MODE), .BOOT_OPT(BOOT_OPT), .SERIAL_DOWNLOAD(SERIAL_DOWNLOAD),
  .START_VECTOR(START_VECTOR), .START_VALID(START_VALID));

// [dv/tb.sv]
`timescale 1ns/1ps
module tb;
  reg clk, rstn, cmd_we, hi_we, lo_we, ext, udm, par, strap;
  reg [7:0] cmd_wd, aw;
  reg [3:0] dwe;
  reg [31:0] dwd;
  reg [1:0] vr;
  reg [15:0] ua, pa16;
  reg [6:0] p;
  reg [5:0] q;
  wire [7:0] crd, ah, al;
  wire [31:0] pd;
  wire deny, busy, stall, lk, sc, sf, bo, sd, sv;
  wire [15:0] vec;
  wire [5:0] g;
  int err_count, check_count;
  logic [19:0] tbl [0:5] = '{{2'h0, 1'h0, 16'h0000, 1'h0}, {2'h0, 1'h1, 16'hDFFF, 1'h1},
    {2'h0, 1'h1, 16'hE000, 1'h0}, {2'h1, 1'h1, 16'h6000, 1'h1}, {2'h1, 1'h1, 16'h5FFF, 1'h0},
    {2'h2, 1'h1, 16'h0000, 1'h0}};
  nv_memory_command_sequencer #(.ERASE_CYCLES(24'd1100)) u_nv_memory_command_sequencer (
    .CLK(clk), .RSTN(rstn), .CORE_RESET(p[6]), .CMD_WE(cmd_we), .CMD_WDATA(cmd_wd),
    .CMD_RDATA(crd), .PAGE_ADDR_HIGH_WE(hi_we), .PAGE_ADDR_LOW_WE(lo_we),
    .PAGE_ADDR_WDATA(aw), .PAGE_ADDR_HIGH(ah), .PAGE_ADDR_LOW(al), .PAGE_DATA_WE(dwe),
    .PAGE_DATA_WDATA(dwd), .PAGE_DATA_REGS(pd), .EXEC_FROM_EXTERNAL(ext), .EXT_DATA_DENY(deny),
    .BUSY(busy), .CORE_STALL(stall), .VARIANT(vr), .USER_DOWNLOAD_MODE(udm),
    .USER_PROG_ADDR(ua), .USER_PROG_RD_REQ(q[0]), .USER_PROG_WR_REQ(q[1]),
    .USER_PROG_RD_GRANT(g[0]), .USER_PROG_WR_GRANT(g[1]), .EXT_CODE_READ_REQ(q[2]),
    .EXT_CODE_READ_GRANT(g[2]), .DOWNLOAD_STRAP_PIN(strap), .PARALLEL_MODE(par),
    .PROG_ADDR(pa16), .SER_PROG_REQ(q[3]), .SER_PROG_GRANT(g[3]), .PAR_PROG_REQ(q[4]),
    .PAR_PROG_GRANT(g[4]), .PAR_READ_REQ(q[5]), .PAR_READ_GRANT(g[5]), .SEC_LOCK_SET(p[0]),
    .SEC_SECURE_SET(p[1]), .SEC_SAFE_SET(p[2]), .CODE_ERASE(p[3]), .BOOT_OPT_SET(p[4]),
    .BOOT_OPT_CLR(p[5]), .LOCK_MODE(lk), .SECURE_MODE(sc), .SERIAL_SAFE_MODE(sf),
    .BOOT_OPT(bo), .SERIAL_DOWNLOAD(sd), .START_VECTOR(vec), .START_VALID(sv));
  always #50 clk = ~clk;
  task tally_and_finish;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // n counts the stalled cycles after the first one
  task cmd(input [7:0] code, output int n);
    @(negedge clk) cmd_we = 1;
    cmd_wd = code;
    @(negedge clk) cmd_we = 0;
    @(negedge clk) n = 0;
    while (stall === 1'b1 && n < 9000) begin
      n++;
      @(negedge clk);
    end
  endtask
  task pw(input [31:0] d, input [3:0] we);
    @(negedge clk) dwe = we;
    dwd = d;
    @(negedge clk) dwe = 0;
  endtask
  task pa(input [7:0] hi, input [7:0] lo);
    @(negedge clk) hi_we = 1;
    aw = hi;
    @(negedge clk) hi_we = 0;
    lo_we = 1;
    aw = lo;
    @(negedge clk) lo_we = 0;
  endtask
  // one-cycle pulses on core reset and security controls
  task pu(input [6:0] v);
    @(negedge clk) p = v;
    @(negedge clk) p = 0;
  endtask
  initial begin
    #3000000;
    err_count++;
    tally_and_finish;
  end
  initial begin
    int n, i;
    {clk, rstn, cmd_we, hi_we, lo_we, ext, udm, par, cmd_wd, aw, dwe, dwd, vr, ua, pa16, p, q} = 0;
    strap = 1;
    repeat (6) @(negedge clk);
    rstn = 1;
    @(negedge clk) q = 6'h3F;
    chk(sv, 1);
    chk(vec, 16'h0000);
    chk(sd, 0);
    cmd(8'h06, n);
    chk(n, 1100);
    chk(crd, 8'h00);
    pa(8'h00, 8'h03);
    chk({ah, al}, 16'h0003);
    pw(32'h11223344, 4'hF);
    cmd(8'h02, n);
    chk(n, 3800);
    pw(0, 4'hF);
    cmd(8'h01, n);
    chk(n, 22);
    chk(pd, 32'h11223344);
    pw(0, 4'hF);
    cmd(8'h02, n);
    cmd(8'h01, n);
    chk(pd, 32'h11223344);
    pw(32'h0000F300, 4'h2);
    chk(pd, 32'h1122F344);
    cmd(8'h05, n);
    chk(n, 1100);
    cmd(8'h04, n);
    chk(crd, 8'h01);
    cmd(8'h02, n);
    cmd(8'h04, n);
    chk(crd, 8'h00);
    pw(0, 4'hF);
    cmd(8'h01, n);
    chk(pd, 32'h1122F344);
    pa(8'h00, 8'h04);
    cmd(8'h01, n);
    chk(pd, 32'hFFFFFFFF);
    // verify with a refused command and page data writes ignored while busy
    @(negedge clk) cmd_we = 1;
    cmd_wd = 8'h04;
    @(negedge clk) cmd_wd = 8'h02;
    dwe = 4'hF;
    chk({busy, stall, crd}, {2'b11, 8'h04});
    @(negedge clk) cmd_we = 0;
    dwe = 0;
    repeat (30) @(negedge clk);
    chk(crd, 8'h00);
    chk(pd, 32'hFFFFFFFF);
    for (i = 0; i < 6; i++) begin
      @(negedge clk) {vr, udm, ua} = tbl[i][19:1];
      #10 chk(g[1], tbl[i][0]);
      chk(g[0], 1);
    end
    @(negedge clk) vr = 0;
    pu(7'h01);
    chk({lk, sc, sf}, 3'b100);
    par = 1;
    #1 chk(g[5:4], 2'b10);
    chk(g[2], 1);
    @(negedge clk) par = 0;
    pu(7'h08);
    chk(lk, 1);
    strap = 0;
    pu(7'h40);
    repeat (2) @(negedge clk);
    chk(sd, 1);
    pa16 = 16'hF000;
    #1 chk(g[3], 1);
    pu(7'h10);
    chk(bo, 1);
    pu(7'h04);
    pu(7'h08);
    chk({lk, sf}, 2'b01);
    pu(7'h40);
    repeat (2) @(negedge clk);
    chk({sv, sd}, 2'b10);
    chk(vec, 16'hE000);
    // a clear outside serial download is refused
    pu(7'h20);
    chk(bo, 1);
    pu(7'h02);
    ext = 1;
    par = 1;
    #1 chk(deny, 1);
    chk(g[2], 0);
    chk(g[5:4], 2'b00);
    cmd(8'h01, n);
    chk(n, 0);
    ext = 0;
    pu(7'h08);
    chk({lk, sc, sf}, 3'b000);
    tally_and_finish;
  end
endmodule
